// file: btbw_core.sv
// Contract
// - Register tests masked by memory nibble, skip
// - Memory tests by immediate mask, skip
// - Inverted memory tests skip on not-all
// - Call pushes pc+1; return pops pc
// - Return-and-skip pops then skips next
// - Jump loads target, stack untouched
// - Table read loads program word into data
// - Table address low nibble from register
// - Table read takes two machine cycles
// - Indirect source move takes two cycles
// - Clock halt only while hold low
// - Ports addressed by instruction and code
// - Address and data registers are ports
// - Absent output port changes nothing else
// - Absent input port loads all ones
// - Unused output codes may be discarded
// - Port bit Y1 is memory LSB
// - Group one output code F sets address reg
module btbw_core #(
  parameter int MC_CYC = btbw_pkg::MC_CYC
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Program memory, one-cycle read latency
  output logic      [11:0] pm_addr,
  input  wire logic [15:0] pm_rdata,
  // Data memory, one-cycle read latency
  output logic      [7:0]  dm_addr,
  output logic             dm_we,
  output logic      [3:0]  dm_wdata,
  input  wire logic [3:0]  dm_rdata,
  // Port bus
  output logic             port_wr,
  output logic             port_rd,
  output logic      [1:0]  port_grp,
  output logic      [3:0]  port_code,
  output logic      [3:0]  port_wdata,
  input  wire logic [3:0]  port_rdata,
  input  wire logic        port_hit,
  // Power control pins
  input  wire logic        hold_n,
  input  wire logic        wake,
  output logic             soft_wait,
  output logic             hard_wait,
  output logic             clk_stop,
  // Internal registers
  output logic      [15:0] data_reg,
  output logic      [3:0]  g_reg
);

  localparam int MCW = $clog2(MC_CYC);
  localparam logic [MCW-1:0] MC_LAST = MCW'(MC_CYC - 1);

  if (MC_CYC < btbw_pkg::MC_MIN) begin : g_mc_check
    $error("MC_CYC too small for the step sequence");
  end

  // ==========================================================
  // Pin synchronisers
  logic [1:0] hold_n_sq;
  logic [1:0] wake_sq;
  logic       hold_n_s;
  logic       wake_s;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hold_n_sq <= 2'h3;
      wake_sq   <= 2'h0;
    end else begin
      hold_n_sq <= {hold_n_sq[0], hold_n};
      wake_sq   <= {wake_sq[0], wake};
    end
  end
  assign hold_n_s = hold_n_sq[1];
  assign wake_s   = wake_sq[1];

  // ==========================================================
  // State and machine cycle counter
  btbw_pkg::btbw_state_e state_q;
  btbw_pkg::btbw_state_e state_d;
  logic [MCW-1:0] mc_q;
  logic           mc_last;
  logic           long_pend_q;
  logic           skip_q;
  logic [11:0]    pc_q;
  logic [15:0]    ir_q;
  logic [3:0]     m_q;
  logic [3:0]     r_q;
  logic [3:0]     x_q;
  logic [15:0]    data_q;
  logic [3:0]     g_q;
  logic [11:0]    pm_addr_q;
  logic [7:0]     dm_addr_q;
  logic           dm_we_q;
  logic [3:0]     dm_wdata_q;
  logic           soft_q;
  logic           hard_q;
  logic           stop_q;
  btbw_stack_if   stk ();

  btbw_stack #(
    .DEPTH (2)
  ) u_stack (
    .mclk  (mclk),
    .rst_n (rst_n),
    .stk   (stk)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n || mc_last) begin
      mc_q <= '0;
    end else begin
      mc_q <= mc_q + MCW'(1);
    end
  end
  assign mc_last = (mc_q == MC_LAST);

  // ==========================================================
  // Decode
  logic [5:0] ic;
  logic [1:0] fa;
  logic [3:0] fb;
  logic [3:0] fc;
  logic       is_call, is_jump, is_ret, is_rets, is_wait, is_halt;
  logic       is_tbl, is_indirect_source_move, is_in, is_out, is_long, is_gset, in_int;
  logic       skip_take;
  logic [3:0] rsel;
  logic [3:0] msel;
  logic [3:0] in_data;

  assign ic = ir_q[btbw_pkg::IC_MSB:btbw_pkg::IC_LSB];
  assign fa = ir_q[btbw_pkg::FA_LSB +: 2];
  assign fb = ir_q[btbw_pkg::FB_LSB +: 4];
  assign fc = ir_q[3:0];

  assign is_call = (ir_q[15:12] == btbw_pkg::OP4_CALL);
  assign is_jump = (ir_q[15:12] == btbw_pkg::OP4_JUMP);
  assign is_ret  = (ic == btbw_pkg::OP_MISC) && (fa == btbw_pkg::FA_RET);
  assign is_rets = (ic == btbw_pkg::OP_MISC) && (fa == btbw_pkg::FA_RETS);
  assign is_wait = (ic == btbw_pkg::OP_MISC) && (fa == btbw_pkg::FA_PWR) && (fb == btbw_pkg::FB_WAIT);
  assign is_halt = (ic == btbw_pkg::OP_MISC) && (fa == btbw_pkg::FA_PWR) && (fb == btbw_pkg::FB_HALT);
  assign is_tbl  = (ic == btbw_pkg::OP_TABLE);
  assign is_indirect_source_move = (ic == btbw_pkg::OP_INDIRECT_SOURCE_MOVE);
  assign is_in   = (ic >= btbw_pkg::OP_IN1) && (ic <= btbw_pkg::OP_IN3);
  assign is_out  = (ic >= btbw_pkg::OP_OUTPUT_GROUP_ONE) && (ic <= btbw_pkg::OP_OUT3);
  assign is_long = is_tbl || is_indirect_source_move;
  assign is_gset = (ic == btbw_pkg::OP_OUTPUT_GROUP_ONE) && (fc == btbw_pkg::CODE_GREG);
  // Data register nibbles answer group one input codes C to F
  assign in_int  = (ic == btbw_pkg::OP_IN1) && (fc[3:2] == btbw_pkg::DREG_CODE_HI);

  assign rsel = r_q & m_q;
  assign msel = m_q & fc;

  always_comb begin
    case (ic)
      btbw_pkg::OP_REG_ONES:  skip_take = (rsel == m_q);
      btbw_pkg::OP_REG_ZEROS: skip_take = (rsel == 4'h0);
      btbw_pkg::OP_MEM_ONES:  skip_take = (msel == fc);
      btbw_pkg::OP_MEM_ZEROS: skip_take = (msel == 4'h0);
      btbw_pkg::OP_MEM_NONES: skip_take = (msel != fc);
      btbw_pkg::OP_MEM_NZERO: skip_take = (msel != 4'h0);
      default:                skip_take = 1'b0;
    endcase
    if (is_call || is_jump) begin
      skip_take = 1'b0;
    end
  end

  // Port group from the operation code; Y1 is bit 0 throughout
  always_comb begin
    case (ic)
      btbw_pkg::OP_IN2,
      btbw_pkg::OP_OUT2: port_grp = btbw_pkg::GRP_TWO;
      btbw_pkg::OP_IN3,
      btbw_pkg::OP_OUT3: port_grp = btbw_pkg::GRP_THREE;
      default:           port_grp = btbw_pkg::GRP_ONE;
    endcase
  end

  always_comb begin
    if (in_int) begin
      in_data = data_q[{fc[1:0], 2'h0} +: 4];
    end else if (port_hit) begin
      in_data = port_rdata;
    end else begin
      in_data = btbw_pkg::PORT_ABSENT;
    end
  end

  // ==========================================================
  // Step sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      btbw_pkg::ST_FETCH: state_d = btbw_pkg::ST_IRW;
      btbw_pkg::ST_IRW:   state_d = btbw_pkg::ST_IR;
      btbw_pkg::ST_IR:    state_d = skip_q ? btbw_pkg::ST_PAD : btbw_pkg::ST_RMW;
      btbw_pkg::ST_RMW:   state_d = btbw_pkg::ST_RM;
      btbw_pkg::ST_RM:    state_d = btbw_pkg::ST_RR;
      btbw_pkg::ST_RR:    state_d = is_long ? btbw_pkg::ST_RXW : btbw_pkg::ST_EXEC;
      btbw_pkg::ST_RXW:   state_d = btbw_pkg::ST_RX;
      btbw_pkg::ST_RX:    state_d = btbw_pkg::ST_EXEC;
      btbw_pkg::ST_EXEC: begin
        if (is_wait || (is_halt && !hold_n_s)) begin
          state_d = btbw_pkg::ST_HALT;
        end else begin
          state_d = btbw_pkg::ST_PAD;
        end
      end
      btbw_pkg::ST_PAD: begin
        if (mc_last && !long_pend_q) begin
          state_d = btbw_pkg::ST_FETCH;
        end
      end
      btbw_pkg::ST_HALT: begin
        if ((stop_q && hold_n_s) || (!stop_q && wake_s)) begin
          state_d = btbw_pkg::ST_PAD;
        end
      end
      default: state_d = btbw_pkg::ST_FETCH;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= btbw_pkg::ST_FETCH;
    end else begin
      state_q <= state_d;
    end
  end

  // Long operations hold the pad over one extra machine cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      long_pend_q <= 1'b0;
    end else if (state_q == btbw_pkg::ST_EXEC && is_long) begin
      long_pend_q <= 1'b1;
    end else if (state_q == btbw_pkg::ST_PAD && mc_last) begin
      long_pend_q <= 1'b0;
    end
  end

  // ==========================================================
  // Program counter, stack and skip
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pc_q <= btbw_pkg::PC_RESET;
    end else if (state_q == btbw_pkg::ST_IR && skip_q) begin
      pc_q <= pc_q + 12'h001;
    end else if (state_q == btbw_pkg::ST_EXEC) begin
      if (is_call || is_jump) begin
        pc_q <= ir_q[11:0];
      end else if (is_ret || is_rets) begin
        pc_q <= stk.top;
      end else begin
        pc_q <= pc_q + 12'h001;
      end
    end
  end

  assign stk.push  = (state_q == btbw_pkg::ST_EXEC) && is_call;
  assign stk.pop   = (state_q == btbw_pkg::ST_EXEC) && !is_call && !is_jump && (is_ret || is_rets);
  assign stk.wdata = pc_q + 12'h001;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      skip_q <= 1'b0;
    end else if (state_q == btbw_pkg::ST_EXEC && (skip_take || (is_rets && !is_call && !is_jump))) begin
      skip_q <= 1'b1;
    end else if (state_q == btbw_pkg::ST_IR) begin
      skip_q <= 1'b0;
    end
  end

  // ==========================================================
  // Operand capture and internal registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ir_q   <= 16'h0000;
      m_q    <= 4'h0;
      r_q    <= 4'h0;
      x_q    <= 4'h0;
      data_q <= btbw_pkg::DREG_RESET;
      g_q    <= btbw_pkg::G_RESET;
    end else begin
      case (state_q)
        btbw_pkg::ST_IR: ir_q <= pm_rdata;
        btbw_pkg::ST_RM: m_q <= dm_rdata;
        btbw_pkg::ST_RR: r_q <= dm_rdata;
        btbw_pkg::ST_RX: begin
          if (is_tbl) begin
            data_q <= pm_rdata;
          end else begin
            x_q <= dm_rdata;
          end
        end
        btbw_pkg::ST_EXEC: begin
          if (is_gset) begin
            g_q <= m_q;
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Memory addresses and write-back
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pm_addr_q <= btbw_pkg::PC_RESET;
    end else if (state_q == btbw_pkg::ST_FETCH) begin
      pm_addr_q <= pc_q;
    end else if (state_q == btbw_pkg::ST_RR && is_tbl) begin
      pm_addr_q <= {btbw_pkg::TBL_PAGE, ir_q[9:4], dm_rdata};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dm_addr_q <= 8'h00;
    end else begin
      case (state_q)
        btbw_pkg::ST_IR:   dm_addr_q <= {btbw_pkg::MEM_BANK, pm_rdata[9:4]};
        btbw_pkg::ST_RMW:  dm_addr_q <= {btbw_pkg::GREG_ROW, fc};
        btbw_pkg::ST_RR:   dm_addr_q <= {g_q, dm_rdata};
        btbw_pkg::ST_EXEC: dm_addr_q <= {btbw_pkg::MEM_BANK, fa, fb};
        default: ;
      endcase
    end
  end

  // Outputs never write memory, so an absent port disturbs nothing
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dm_we_q    <= 1'b0;
      dm_wdata_q <= 4'h0;
    end else if (state_q == btbw_pkg::ST_EXEC && (is_in || is_indirect_source_move)) begin
      dm_we_q    <= 1'b1;
      dm_wdata_q <= is_indirect_source_move ? x_q : in_data;
    end else begin
      dm_we_q <= 1'b0;
    end
  end

  // Unused output codes still strobe; the port logic drops them
  assign port_wr    = (state_q == btbw_pkg::ST_EXEC) && is_out && !is_gset;
  assign port_rd    = (state_q == btbw_pkg::ST_EXEC) && is_in && !in_int;
  assign port_code  = fc;
  assign port_wdata = m_q;

  // ==========================================================
  // Wait and clock halt
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      soft_q <= 1'b0;
      hard_q <= 1'b0;
      stop_q <= 1'b0;
    end else if (state_q == btbw_pkg::ST_EXEC) begin
      soft_q <= is_wait && !fc[0];
      hard_q <= is_wait && fc[0];
      stop_q <= is_halt && !hold_n_s;
    end else if (state_q == btbw_pkg::ST_HALT && state_d == btbw_pkg::ST_PAD) begin
      soft_q <= 1'b0;
      hard_q <= 1'b0;
      stop_q <= 1'b0;
    end
  end

  assign pm_addr   = pm_addr_q;
  assign dm_addr   = dm_addr_q;
  assign dm_we     = dm_we_q;
  assign dm_wdata  = dm_wdata_q;
  assign soft_wait = soft_q;
  assign hard_wait = hard_q;
  assign clk_stop  = stop_q;
  assign data_reg  = data_q;
  assign g_reg     = g_q;

  // ==========================================================
  // Checks
  a_reg_test_skip: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == btbw_pkg::ST_EXEC && ic == btbw_pkg::OP_REG_ZEROS && (r_q & m_q) == 4'h0 |=> skip_q)
    else $error("register zero test did not skip");

  a_mem_test_skip: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == btbw_pkg::ST_EXEC && ic == btbw_pkg::OP_MEM_ONES && (m_q & fc) != fc |=> !skip_q)
    else $error("memory ones test skipped wrongly");

  a_mem_inv_skip: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == btbw_pkg::ST_EXEC && ic == btbw_pkg::OP_MEM_NZERO && (m_q & fc) != 4'h0 |=> skip_q)
    else $error("not-all-zero test did not skip");

  a_call_target: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == btbw_pkg::ST_EXEC && is_call |=> pc_q == $past(ir_q[11:0]) && stk.top == $past(pc_q) + 12'h001)
    else $error("call did not push return address");

  a_rets_skip: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == btbw_pkg::ST_EXEC && is_rets && !is_call && !is_jump |=> skip_q && pc_q == $past(stk.top))
    else $error("return-and-skip failed");

  a_jump_stack: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == btbw_pkg::ST_EXEC && is_jump |=> $stable(stk.top) && pc_q == $past(ir_q[11:0]))
    else $error("jump touched the stack");

  a_table_addr: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == btbw_pkg::ST_RR && is_tbl |=> pm_addr_q[3:0] == $past(dm_rdata) && pm_addr_q[11:10] == 2'h0)
    else $error("table address wrong");

  a_long_two: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == btbw_pkg::ST_EXEC && is_long |=> long_pend_q throughout (state_q == btbw_pkg::ST_PAD)[*3])
    else $error("long operation finished in one cycle");

  a_skip_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == btbw_pkg::ST_IR && skip_q |=> state_q == btbw_pkg::ST_PAD && pc_q == $past(pc_q) + 12'h001)
    else $error("skipped instruction handled wrongly");

  a_absent_input: assert property (@(posedge mclk) disable iff (!rst_n)
    port_rd && !port_hit |=> dm_we_q && dm_wdata_q == 4'hf)
    else $error("absent input port did not read ones");

  a_out_no_write: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == btbw_pkg::ST_EXEC && is_out |=> !dm_we_q)
    else $error("output wrote data memory");

  a_greg_set: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == btbw_pkg::ST_EXEC && is_gset |=> g_q == $past(m_q) && !$past(port_wr))
    else $error("address register not loaded");

  a_halt_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    stop_q && hold_n_s && state_q == btbw_pkg::ST_HALT |=> !stop_q ##1 !stop_q)
    else $error("clock halt held with hold high");

  a_wait_kind: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == btbw_pkg::ST_EXEC && is_wait |=> hard_q == $past(fc[0]) && soft_q == !$past(fc[0]))
    else $error("wait mode chosen wrongly");

endmodule

// file: btbw_pkg.sv
package btbw_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int MCYC_TIME_NS  = 40000;
  localparam int MC_CYC        = MCYC_TIME_NS / CLK_PERIOD_NS;
  localparam int MC_MIN        = 16;

  // ==========================================================
  // Instruction fields
  localparam int IC_MSB = 15;
  localparam int IC_LSB = 10;
  localparam int FA_LSB = 8;
  localparam int FB_LSB = 4;

  // ==========================================================
  // Six-bit operation codes
  localparam logic [5:0] OP_REG_ONES  = 6'h20;
  localparam logic [5:0] OP_REG_ZEROS = 6'h21;
  localparam logic [5:0] OP_MEM_NONES = 6'h34;
  localparam logic [5:0] OP_MEM_ONES  = 6'h35;
  localparam logic [5:0] OP_MEM_NZERO = 6'h36;
  localparam logic [5:0] OP_MEM_ZEROS = 6'h37;
  localparam logic [5:0] OP_INDIRECT_SOURCE_MOVE      = 6'h27;
  localparam logic [5:0] OP_IN1       = 6'h38;
  localparam logic [5:0] OP_IN2       = 6'h39;
  localparam logic [5:0] OP_IN3       = 6'h3a;
  localparam logic [5:0] OP_OUTPUT_GROUP_ONE      = 6'h3b;
  localparam logic [5:0] OP_OUT2      = 6'h3c;
  localparam logic [5:0] OP_OUT3      = 6'h3d;
  localparam logic [5:0] OP_TABLE     = 6'h3e;
  localparam logic [5:0] OP_MISC      = 6'h3f;

  // Four-bit operation codes with a 12-bit target
  localparam logic [3:0] OP4_CALL = 4'ha;
  localparam logic [3:0] OP4_JUMP = 4'hb;

  // Misc group A and B fields
  localparam logic [1:0] FA_RET   = 2'h0;
  localparam logic [1:0] FA_RETS  = 2'h1;
  localparam logic [1:0] FA_PWR   = 2'h2;
  localparam logic [3:0] FB_WAIT  = 4'h0;
  localparam logic [3:0] FB_HALT  = 4'h8;

  // ==========================================================
  // Port map
  localparam logic [3:0] CODE_GREG     = 4'hf;
  localparam logic [1:0] DREG_CODE_HI  = 2'h3;
  localparam logic [3:0] PORT_ABSENT   = 4'hf;
  localparam logic [1:0] GRP_ONE       = 2'h0;
  localparam logic [1:0] GRP_TWO       = 2'h1;
  localparam logic [1:0] GRP_THREE     = 2'h2;

  // ==========================================================
  // Memory layout and reset values
  localparam logic [3:0]  GREG_ROW   = 4'hf;
  localparam logic [1:0]  MEM_BANK   = 2'h0;
  localparam logic [1:0]  TBL_PAGE   = 2'h0;
  localparam logic [11:0] PC_RESET   = 12'h000;
  localparam logic [15:0] DREG_RESET = 16'h0000;
  localparam logic [3:0]  G_RESET    = 4'h0;

  typedef enum logic [3:0] {
    ST_FETCH = 4'h0,
    ST_IRW   = 4'h1,
    ST_IR    = 4'h2,
    ST_RMW   = 4'h3,
    ST_RM    = 4'h4,
    ST_RR    = 4'h5,
    ST_RXW   = 4'h6,
    ST_RX    = 4'h7,
    ST_EXEC  = 4'h8,
    ST_PAD   = 4'h9,
    ST_HALT  = 4'ha
  } btbw_state_e;

endpackage

// file: btbw_stack_if.sv
interface btbw_stack_if;
  logic        push;
  logic        pop;
  logic [11:0] wdata;
  logic [11:0] top;

  modport owner (input push, input pop, input wdata, output top);
  modport user  (output push, output pop, output wdata, input top);
endinterface

// file: btbw_stack.sv
module btbw_stack #(
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic     mclk,
  input wire logic     rst_n,
  // Stack access
  btbw_stack_if.owner  stk
);

  // ==========================================================
  // Storage
  logic [11:0] lvl_q [DEPTH];

  if (DEPTH < 2) begin : g_depth_check
    $error("btbw_stack needs at least two levels");
  end

  // Overflow drops the oldest entry, as a short hardware stack does
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        lvl_q[i] <= btbw_pkg::PC_RESET;
      end
    end else if (stk.push) begin
      lvl_q[0] <= stk.wdata;
      for (int i = 1; i < DEPTH; i++) begin
        lvl_q[i] <= lvl_q[i-1];
      end
    end else if (stk.pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        lvl_q[i] <= lvl_q[i+1];
      end
    end
  end

  assign stk.top = lvl_q[0];

endmodule

// file: btbw_mem_model.sv
module btbw_mem_model (
  // Clock
  input  wire logic        mclk,
  // Program memory
  input  wire logic [11:0] pm_addr,
  output logic      [15:0] pm_rdata,
  // Data memory
  input  wire logic [7:0]  dm_addr,
  input  wire logic        dm_we,
  input  wire logic [3:0]  dm_wdata,
  output logic      [3:0]  dm_rdata,
  // Port bus
  input  wire logic        port_rd,
  input  wire logic [1:0]  port_grp,
  input  wire logic [3:0]  port_code,
  output logic      [3:0]  port_rdata,
  output logic             port_hit
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Memories, loaded by the bench before reset ends
  logic [15:0] pm [4096];
  logic [3:0]  dm [256];
  logic [3:0]  noise_q = 4'h5;

  always @(posedge mclk) begin
    pm_rdata <= pm[pm_addr];
    dm_rdata <= dm[dm_addr];
    if (dm_we) begin
      dm[dm_addr] <= dm_wdata;
    end
    noise_q <= ~noise_q + 4'h3;
  end

  // ==========================================================
  // Port logic: codes 8..f are absent
  // An absent port leaves the bus floating, so a changing pattern stands in
  assign port_hit   = port_rd & ~port_code[3];
  assign port_rdata = port_hit ? (port_code ^ {port_grp, 2'b10}) : noise_q;
endmodule

// file: bit_test_branch_wait_io_decode_tb.sv
module bit_test_branch_wait_io_decode_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MC = btbw_pkg::MC_MIN;

  logic        mclk   = 1'b0;
  logic        rst_n  = 1'b0;
  logic        hold_n = 1'b1;
  logic        wake   = 1'b0;
  logic [11:0] pm_addr;
  logic [15:0] pm_rdata;
  logic [7:0]  dm_addr;
  logic        dm_we;
  logic [3:0]  dm_wdata;
  logic [3:0]  dm_rdata;
  logic        port_wr;
  logic        port_rd;
  logic [1:0]  port_grp;
  logic [3:0]  port_code;
  logic [3:0]  port_wdata;
  logic [3:0]  port_rdata;
  logic        port_hit;
  logic        soft_wait;
  logic        hard_wait;
  logic        clk_stop;
  logic [15:0] data_reg;
  logic [3:0]  g_reg;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          seed = 32'h2b0b;
  int          mdm [256];
  int          stk [$];
  int          pexp [$];
  int          pc, dreg, greg, skip, len;

  always #50 mclk = ~mclk;

  btbw_core #(.MC_CYC(MC)) btbw_core_inst (.mclk(mclk), .rst_n(rst_n), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .dm_addr(dm_addr), .dm_we(dm_we), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .port_wr(port_wr),
    .port_rd(port_rd), .port_grp(port_grp), .port_code(port_code), .port_wdata(port_wdata),
    .port_rdata(port_rdata), .port_hit(port_hit), .hold_n(hold_n), .wake(wake), .soft_wait(soft_wait),
    .hard_wait(hard_wait), .clk_stop(clk_stop), .data_reg(data_reg), .g_reg(g_reg));

  btbw_mem_model btbw_mem_model_inst (.mclk(mclk), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_addr(dm_addr),
    .dm_we(dm_we), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .port_rd(port_rd), .port_grp(port_grp),
    .port_code(port_code), .port_rdata(port_rdata), .port_hit(port_hit));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d, comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Output strobes are looked at mid-cycle, well clear of the edge that raises them
  always @(negedge mclk) begin
    if (port_wr === 1'b1) begin
      if (pexp.size() == 0) pexp.push_back(16'hffff);
      check(16'({port_grp, port_code, port_wdata}), 16'(pexp.pop_front()));
    end
  end

  function automatic logic [15:0] ins(input int op, input int m, input int c);
    return 16'((op << 10) | (m << 4) | c);
  endfunction

  // ==========================================================
  // Reference model: one instruction per call
  task automatic step();
    logic [15:0] w;
    int op, m, c, nxt;
    w = btbw_mem_model_inst.pm[pc];
    op = int'(w[15:10]);
    m = int'(w[9:4]);
    c = int'(w[3:0]);
    nxt = pc + 1;
    len = 1;
    if (skip != 0) skip = 0;
    else if (w[15:12] == 4'ha) begin
      stk.push_back(pc + 1);
      nxt = int'(w[11:0]);
    end else if (w[15:12] == 4'hb) nxt = int'(w[11:0]);
    else case (op)
      6'h20: skip = int'((mdm[240 + c] & mdm[m]) == mdm[m]);
      6'h21: skip = int'((mdm[240 + c] & mdm[m]) == 0);
      6'h35: skip = int'((mdm[m] & c) == c);
      6'h34: skip = int'((mdm[m] & c) != c);
      6'h37: skip = int'((mdm[m] & c) == 0);
      6'h36: skip = int'((mdm[m] & c) != 0);
      6'h3e: begin
        dreg = int'(btbw_mem_model_inst.pm[(m << 4) | mdm[240 + c]]);
        len = 2;
      end
      6'h27: begin
        mdm[m] = mdm[(greg << 4) | mdm[240 + c]];
        len = 2;
      end
      6'h38, 6'h39, 6'h3a: begin
        if (op == 6'h38 && c >= 12) mdm[m] = (dreg >> (4 * (c - 12))) & 15;
        else mdm[m] = (c < 8) ? (c ^ (((op - 56) << 2) | 2)) : 15;
      end
      6'h3b, 6'h3c, 6'h3d: begin
        if (op == 6'h3b && c == 15) greg = mdm[m];
        else pexp.push_back(((op - 59) << 8) | (c << 4) | mdm[m]);
      end
      6'h3f: if (w[9:8] < 2'h2) begin
        nxt = stk.pop_back();
        skip = int'(w[8]);
      end
      default: ;
    endcase
    pc = nxt & 12'hfff;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    for (int i = 0; i < 256; i++) begin
      btbw_mem_model_inst.dm[i] = 4'($random(seed)) | ((i == 5) ? 4'h1 : 4'h0);
      mdm[i] = int'(btbw_mem_model_inst.dm[i]);
    end
    for (int i = 0; i < 16; i++) btbw_mem_model_inst.pm[12'h050 + i] = 16'($random(seed));
    btbw_mem_model_inst.pm[12'h000] = 16'hb100;
    btbw_mem_model_inst.pm[12'h100] = 16'ha200;
    btbw_mem_model_inst.pm[12'h200] = 16'ha300;
    btbw_mem_model_inst.pm[12'h201] = 16'hff00;
    btbw_mem_model_inst.pm[12'h202] = 16'hfc00;
    btbw_mem_model_inst.pm[12'h300] = 16'hfd00;
    for (int i = 0; i < 4; i++) begin
      btbw_mem_model_inst.pm[12'h101 + 2 * i] = ins(6'h34 + i, 1, ($random(seed) & 15) | 1);
    end
    btbw_mem_model_inst.pm[12'h102] = ins(6'h3b, 2, 15);
    btbw_mem_model_inst.pm[12'h104] = ins(6'h38, 3, 9);
    btbw_mem_model_inst.pm[12'h106] = ins(6'h39, 4, 2);
    btbw_mem_model_inst.pm[12'h108] = ins(6'h3e, 5, 1);
    btbw_mem_model_inst.pm[12'h109] = ins(6'h20, 5, 2);
    btbw_mem_model_inst.pm[12'h10a] = 16'hff00;
    btbw_mem_model_inst.pm[12'h10b] = ins(6'h21, 5, 3);
    btbw_mem_model_inst.pm[12'h10c] = ins(6'h27, 6, 4);
    btbw_mem_model_inst.pm[12'h10d] = ins(6'h38, 7, 12);
    btbw_mem_model_inst.pm[12'h10e] = 16'hfe80;
    btbw_mem_model_inst.pm[12'h10f] = ins(6'h3c, 8, 5);
    btbw_mem_model_inst.pm[12'h110] = ins(6'h3d, 9, 8);
    btbw_mem_model_inst.pm[12'h111] = 16'hfe01;
    btbw_mem_model_inst.pm[12'h112] = 16'hfe80;
    btbw_mem_model_inst.pm[12'h113] = 16'hfe00;
    repeat (8) @(posedge mclk);
    #2 rst_n = 1'b1;
    @(posedge mclk);
    #2;
    while (pc != 12'h111) begin
      check(16'(pm_addr), 16'(pc));
      check(data_reg, 16'(dreg));
      check(16'(g_reg), 16'(greg));
      step();
      repeat (MC * len) @(posedge mclk);
      #2;
    end
    check(16'(pm_addr), 16'(pc));
    repeat (MC) @(posedge mclk);
    #2;
    check(16'(hard_wait), 16'h1);
    check(16'({soft_wait, clk_stop}), 16'h0);
    wake = 1'b1;
    repeat (MC) @(posedge mclk);
    #2;
    check(16'(hard_wait), 16'h0);
    // Clock halt with hold low, then a soft wait that stays asleep
    wake = 1'b0;
    hold_n = 1'b0;
    repeat (MC) @(posedge mclk);
    #2;
    check(16'({soft_wait, hard_wait, clk_stop}), 16'h1);
    hold_n = 1'b1;
    repeat (MC) @(posedge mclk);
    #2;
    check(16'(pm_addr), 16'h113);
    repeat (MC) @(posedge mclk);
    #2;
    check(16'({soft_wait, hard_wait, clk_stop}), 16'h4);
    check(16'(pexp.size()), 16'h0);
    for (int i = 0; i < 256; i++) begin
      check(16'(btbw_mem_model_inst.dm[i]), 16'(mdm[i]));
    end
    give_verdict();
  end

  // Bounded run: the program needs well under a millisecond
  initial begin
    #2ms;
    num_errors++;
    give_verdict();
  end
endmodule
